//--- bench/flash_read_limit_and_timing_tb.sv
// self-checking bench for the flash read limit and timing block
// assumes frl_top with the core model on its core side and an axi4-lite master here
`timescale 1ns/1ps
`default_nettype none
`include "frl_defs.svh"
module flash_read_limit_and_timing_tb;
    typedef struct packed {
        frl_pkg::frl_op_t op;
        logic [15:0] addr;
        logic [7:0] data;
        logic [19:0] len;
    } frl_cmd_exp_t;
    localparam logic [11:0] adr_tim = {2'b00, `FRL_IDX_TIMING, 2'b00};
    localparam logic [11:0] adr_lim = {2'b00, `FRL_IDX_LIMIT, 2'b00};
    localparam logic [11:0] adr_sto = {2'b00, `FRL_IDX_STORE, 2'b00};
    localparam logic [11:0] adr_sta = {2'b00, `FRL_IDX_STATUS, 2'b00};
    localparam logic [1:0] ok_r = `FRL_RESP_OKAY;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, rd_valid_q, fl_cmd_valid_q, cpu_stall_q;
    logic oneshot_timer_en_q, read_always_en_q, rd_req, rd_is_fetch, wr_req, tp_erase_req, hung;
    logic [1:0] bresp, rresp;
    logic [7:0] rd_data_q, fl_wdata_q, flash_rdata, wr_data;
    logic [15:0] fl_addr_q, cur_pc, rd_addr, wr_addr, tp_erase_addr;
    frl_pkg::frl_op_t fl_cmd_q;
    int fail_count = 0, samples_checked = 0, stall_n = 0;
    logic [7:0] cur_limit = 8'h00, tim = `FRL_TIMING_RESET;
    logic [1:0] store = 2'b00;
    logic counting = 1'b0;
    logic [33:0] rq_axi[$];
    logic [1:0] bq[$];
    logic [7:0] rq_core[$];
    frl_cmd_exp_t cq[$];
    frl_cmd_exp_t cur;
    logic [7:0] codes[4] = '{8'hf0, 8'h71, 8'hb2, 8'h0a};
    logic [15:0] tpa[4] = '{16'h7dfe, 16'h7dff, 16'h7c40, 16'h1234};

    frl_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cur_pc(cur_pc), .rd_req(rd_req), .rd_is_fetch(rd_is_fetch), .rd_addr(rd_addr),
        .flash_rdata(flash_rdata), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .tp_erase_req(tp_erase_req),
        .tp_erase_addr(tp_erase_addr), .fl_cmd_valid_q(fl_cmd_valid_q), .fl_cmd_q(fl_cmd_q),
        .fl_addr_q(fl_addr_q), .fl_wdata_q(fl_wdata_q), .cpu_stall_q(cpu_stall_q),
        .oneshot_timer_en_q(oneshot_timer_en_q), .read_always_en_q(read_always_en_q));
    frl_core_model core (.aclk(aclk), .cpu_stall_q(cpu_stall_q), .cur_pc(cur_pc),
        .rd_req(rd_req), .rd_is_fetch(rd_is_fetch), .rd_addr(rd_addr),
        .flash_rdata(flash_rdata), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .tp_erase_req(tp_erase_req), .tp_erase_addr(tp_erase_addr), .hung(hung));

    always #10 aclk = ~aclk;

    task automatic finish_test();
        if (rq_axi.size() + bq.size() + rq_core.size() + cq.size() != 0) begin
            fail_count++;
            $display("wrong value pending results expected 0 seen nonzero");
        end
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic give_up();
        fail_count++;
        $display("wrong value wait bound expected done seen hang");
        finish_test();
    endtask
    task automatic cmp_bus(input string what, input logic [33:0] e, input logic [33:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] e);
        cmp_bus("rd_data_q", {26'h0, e}, {26'h0, rd_data_q});
    endtask
    task automatic cmp_cmd(input frl_cmd_exp_t e);
        cmp_bus("fl_cmd_q", 34'(e.op), 34'(fl_cmd_q));
        cmp_bus("fl_addr_q", 34'(e.addr), 34'(fl_addr_q));
        if (e.op == frl_pkg::OP_PROG) cmp_bus("fl_wdata_q", 34'(e.data), 34'(fl_wdata_q));
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        bq.push_back(r);
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'($urandom), 4'hf};
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        if (n >= 100) give_up();
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        rq_axi.push_back({r, 24'h0, d});
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        if (n >= 100) give_up();
    endtask
    function automatic logic guarded(input logic [15:0] pc, input logic [15:0] a);
        return pc[15:8] >= cur_limit && a[15:8] < cur_limit && a[15:1] != 15'h3eff;
    endfunction
    function automatic logic [19:0] dur(input logic [19:0] base);
        return base << ((tim[3:0] > `FRL_PRESC_MAX) ? `FRL_PRESC_MAX : tim[3:0]);
    endfunction
    task automatic rd(input logic [15:0] pc, input logic [15:0] a, input logic f);
        rq_core.push_back((!f && guarded(pc, a)) ? 8'h00 : core.fl_byte(a));
        core.read(pc, a, f);
    endtask
    task automatic wr(input logic [15:0] pc, input logic [15:0] a);
        logic [7:0] d;
        logic ok;
        d = 8'($urandom);
        ok = store[0] && tim[3:0] != `FRL_PRESC_OFF && !guarded(pc, a);
        ok = ok && !(store[1] && a[15:9] == `FRL_LOCK_SECTOR);
        if (ok && store[1]) begin
            cq.push_back(frl_cmd_exp_t'{frl_pkg::OP_SECTOR, {a[15:9], 9'h0}, d,
                                        dur(20'(`FRL_ERASE_TICKS))});
        end else if (ok) begin
            cq.push_back(frl_cmd_exp_t'{frl_pkg::OP_PROG, a, d, dur(20'(`FRL_WRITE_TICKS))});
        end
        core.write(pc, a, d);
    endtask
    task automatic tpe(input logic [15:0] a);
        frl_pkg::frl_op_t op;
        op = (a[15:1] == 15'h3eff) ? frl_pkg::OP_MASS : frl_pkg::OP_SECTOR;
        cq.push_back(frl_cmd_exp_t'{op, {a[15:9], 9'h0}, 8'h00, dur(20'(`FRL_ERASE_TICKS))});
        core.erase(a);
    endtask
    task automatic set_timing(input logic [7:0] v);
        core.wait_idle();
        axi_wr(adr_tim, v, ok_r);
        tim = {v[7:6], 2'b00, v[3:0]};
    endtask
    task automatic set_store(input logic [1:0] v);
        axi_wr(adr_sto, {6'h0, v}, ok_r);
        store = v;
    endtask

    always @(posedge aclk) begin
        if (hung === 1'b1) give_up();
        if (bvalid === 1'b1 && bready === 1'b1) cmp_bus("bresp", 34'(bq.pop_front()), 34'(bresp));
        if (rvalid === 1'b1 && rready === 1'b1) begin
            cmp_bus("rdata", rq_axi.pop_front(), {rresp, rdata});
        end
        if (rd_valid_q === 1'b1) cmp_byte(rq_core.pop_front());
        if (fl_cmd_valid_q === 1'b1) begin
            cur = cq.pop_front();
            cmp_cmd(cur);
            counting = 1'b1;
            stall_n = 0;
        end
        if (counting && cpu_stall_q === 1'b1) stall_n++;
        else if (counting) begin
            counting = 1'b0;
            cmp_bus("stall cycles", 34'(cur.len), 34'(stall_n));
        end
    end

    initial begin
        repeat (100000) @(posedge aclk);
        give_up();
    end

    initial begin
        void'($urandom(32'h2c471fb7));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(adr_tim, `FRL_TIMING_RESET, ok_r);
        axi_rd(adr_lim, `FRL_LIMIT_RESET, ok_r);
        axi_rd(adr_sto, 8'h00, ok_r);
        axi_rd(adr_sta, 8'h00, ok_r);
        axi_rd(12'h004, 8'h00, `FRL_RESP_SLVERR);
        axi_wr(12'h004, 8'hff, `FRL_RESP_SLVERR);
        repeat (8) rd(16'($urandom), 16'($urandom), 1'($urandom));
        set_store(2'b01);
        wr(16'h0100, 16'h6001);
        foreach (codes[i]) begin
            set_timing(codes[i]);
            axi_rd(adr_tim, tim, ok_r);
            cmp_bus("enables", 34'(codes[i][7:6]),
                    34'({oneshot_timer_en_q, read_always_en_q}));
            wr(16'h0100, 16'h6010 + 16'(i));
        end
        set_timing(8'h00);
        set_store(2'b00);
        wr(16'h0100, 16'h6020);
        set_store(2'b01);
        axi_wr(adr_lim, 8'h80, ok_r);
        cur_limit = 8'h80;
        axi_wr(adr_lim, 8'h10, ok_r);
        axi_rd(adr_lim, 8'h80, ok_r);
        axi_rd(adr_sta, 8'h01, ok_r);
        rd(16'h8000, 16'h7fff, 1'b0);
        rd(16'h8010, 16'h7dff, 1'b0);
        rd(16'h8010, 16'h0100, 1'b1);
        rd(16'h7fff, 16'h0000, 1'b0);
        repeat (30) rd(16'($urandom), 16'($urandom), 1'($urandom));
        wr(16'h8010, 16'h3000);
        wr(16'h8010, 16'h7dfe);
        wr(16'h0100, 16'h3000);
        set_store(2'b11);
        wr(16'h8010, 16'h9123);
        wr(16'h0100, 16'h7c10);
        wr(16'h8010, 16'h2000);
        set_store(2'b01);
        set_timing(8'h0f);
        wr(16'h0100, 16'h6100);
        set_timing(8'h00);
        foreach (tpa[i]) tpe(tpa[i]);
        core.wait_idle();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        {cur_limit, tim, store} = {8'h00, `FRL_TIMING_RESET, 2'b00};
        axi_rd(adr_tim, `FRL_TIMING_RESET, ok_r);
        axi_rd(adr_lim, `FRL_LIMIT_RESET, ok_r);
        axi_rd(adr_sta, 8'h00, ok_r);
        rd(16'h8000, 16'h7fff, 1'b0);
        axi_wr(adr_lim, 8'h20, ok_r);
        axi_rd(adr_lim, 8'h20, ok_r);
        axi_rd(adr_sta, 8'h01, ok_r);
        repeat (20) @(posedge aclk);
        finish_test();
    end
endmodule // flash_read_limit_and_timing_tb
`default_nettype wire

//--- bench/frl_core_model.sv
// core-side partner: program memory reads, flash writes and test-port erases
// assumes the flash byte at rd_addr is wanted in the cycle of rd_req
`timescale 1ns/1ps
`default_nettype none
module frl_core_model (
    input wire logic aclk,
    input wire logic cpu_stall_q,
    output logic [15:0] cur_pc,
    output logic rd_req,
    output logic rd_is_fetch,
    output logic [15:0] rd_addr,
    output logic [7:0] flash_rdata,
    output logic wr_req,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    output logic tp_erase_req,
    output logic [15:0] tp_erase_addr,
    output logic hung
);
    function automatic logic [7:0] fl_byte(input logic [15:0] a);
        return a[7:0] ^ {a[14:8], a[15]} ^ 8'h3c;
    endfunction
    // idle byte is inverted so a stale capture never looks right
    assign flash_rdata = rd_req ? fl_byte(rd_addr) : ~fl_byte(rd_addr);
    initial begin
        {cur_pc, rd_req, rd_is_fetch, rd_addr, wr_req, wr_addr, wr_data} = '0;
        {tp_erase_req, tp_erase_addr, hung} = '0;
    end
    task automatic wait_idle();
        int n;
        n = 0;
        while (cpu_stall_q !== 1'b0 && n < 4000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 4000) hung <= 1'b1;
    endtask
    task automatic read(input logic [15:0] pc, input logic [15:0] a, input logic f);
        @(posedge aclk);
        wait_idle();
        {cur_pc, rd_addr, rd_is_fetch, rd_req} <= {pc, a, f, 1'b1};
        @(posedge aclk);
        rd_req <= 1'b0;
    endtask
    // extra edge at the end lets a started stall become visible
    task automatic write(input logic [15:0] pc, input logic [15:0] a, input logic [7:0] d);
        @(posedge aclk);
        wait_idle();
        {cur_pc, wr_addr, wr_data, wr_req} <= {pc, a, d, 1'b1};
        @(posedge aclk);
        wr_req <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic erase(input logic [15:0] a);
        @(posedge aclk);
        wait_idle();
        {tp_erase_addr, tp_erase_req} <= {a, 1'b1};
        @(posedge aclk);
        tp_erase_req <= 1'b0;
        @(posedge aclk);
    endtask
endmodule // frl_core_model
`default_nettype wire

//--- inc/frl_defs.svh
// constants of the flash read limit and timing block: offsets, fields, resets, timing
// assumes a 50 MHz system clock and byte-wide flash behind the block
`ifndef FRL_DEFS_SVH
`define FRL_DEFS_SVH

// register indices; byte address is four times the index
`define FRL_IDX_STORE 8'h8f
`define FRL_IDX_TIMING 8'hb6
`define FRL_IDX_LIMIT 8'hb7
`define FRL_IDX_STATUS 8'hc0

`define FRL_TIMING_RESET 8'h0f
`define FRL_LIMIT_RESET 8'h00
`define FRL_STORE_RESET 2'h0

`define FRL_TM_ONESHOT 7
`define FRL_TM_READ_ALWAYS 6
`define FRL_PRESC_OFF 4'hf
`define FRL_PRESC_MAX 4'ha
`define FRL_ST_WRITE_EN 0
`define FRL_ST_ERASE_EN 1

`define FRL_LOCK_WE_ADDR 16'h7dfe
`define FRL_LOCK_RD_ADDR 16'h7dff
`define FRL_LOCK_SECTOR 7'h3e

`define FRL_BASE_PERIOD_NS 20000
`define FRL_WRITE_TIME_NS 40000
`define FRL_ERASE_TIME_NS 10000000
`define FRL_WRITE_TICKS (`FRL_WRITE_TIME_NS / `FRL_BASE_PERIOD_NS)
`define FRL_ERASE_TICKS (`FRL_ERASE_TIME_NS / `FRL_BASE_PERIOD_NS)

`define FRL_RESP_OKAY 2'b00
`define FRL_RESP_SLVERR 2'b10

`endif

//--- inc/frl_pkg.sv
// types of the flash read limit and timing block
// assumes frl_defs.svh is included by the modules for constants
package frl_pkg;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_PROG = 2'b01,
        OP_SECTOR = 2'b11,
        OP_MASS = 2'b10
    } frl_op_t;

    typedef enum logic {
        T_IDLE = 1'b0,
        T_RUN = 1'b1
    } frl_tstate_t;
endpackage

//--- src/frl_timer.sv
// write and erase duration timer scaled by the prescaler code
// assumes start only arrives while busy is low
`timescale 1ns/1ps
`default_nettype none
`include "frl_defs.svh"
module frl_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic long_op,
    input wire logic [3:0] prescale,
    output logic busy,
    output logic last
);
    frl_pkg::frl_tstate_t state_q;
    logic [19:0] cnt_q;
    logic [3:0] shift;
    logic [19:0] dur;

    // each code up to FRL_PRESC_MAX doubles the clock range, so doubles the cycles per base period; higher codes act as FRL_PRESC_MAX
    // prescaled duration
    always_comb begin
        shift = (prescale > `FRL_PRESC_MAX) ? `FRL_PRESC_MAX : prescale;
        dur = (long_op ? 20'(`FRL_ERASE_TICKS) : 20'(`FRL_WRITE_TICKS)) << shift;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= frl_pkg::T_IDLE;
            cnt_q <= 20'h0;
        end else begin
            case (state_q)
                frl_pkg::T_IDLE: begin
                    if (start) begin
                        state_q <= frl_pkg::T_RUN;
                        cnt_q <= dur - 20'h1;
                    end
                end
                frl_pkg::T_RUN: begin
                    if (cnt_q == 20'h0) begin
                        state_q <= frl_pkg::T_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 20'h1;
                    end
                end
                default: state_q <= frl_pkg::T_IDLE;
            endcase
        end
    end

    assign busy = (state_q == frl_pkg::T_RUN);
    assign last = busy && (cnt_q == 20'h0);
endmodule // frl_timer
`default_nettype wire

//--- src/frl_top.sv
// flash access guard and timing control with an axi4-lite register slave
// assumes flash_rdata is valid in the cycle of rd_req and the core honours cpu_stall_q
`timescale 1ns/1ps
`default_nettype none
`include "frl_defs.svh"
module frl_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [15:0] cur_pc,
    input wire logic rd_req,
    input wire logic rd_is_fetch,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0] flash_rdata,
    output logic rd_valid_q,
    output logic [7:0] rd_data_q,
    input wire logic wr_req,
    input wire logic [15:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic tp_erase_req,
    input wire logic [15:0] tp_erase_addr,
    output logic fl_cmd_valid_q,
    output frl_pkg::frl_op_t fl_cmd_q,
    output logic [15:0] fl_addr_q,
    output logic [7:0] fl_wdata_q,
    output logic cpu_stall_q,
    output logic oneshot_timer_en_q,
    output logic read_always_en_q
);
    function automatic logic is_lock_byte(input logic [15:0] a);
        return (a == `FRL_LOCK_WE_ADDR) || (a == `FRL_LOCK_RD_ADDR);
    endfunction

    function automatic logic in_lock_sector(input logic [15:0] a);
        return a[15:9] == `FRL_LOCK_SECTOR;
    endfunction

    function automatic logic valid_index(input logic [11:0] a, input logic [7:0] idx);
        return (a[11:10] == 2'b00) && (a[9:2] == idx);
    endfunction

    logic [7:0] read_limit_high_byte_q;
    logic limit_written_q;
    logic [3:0] write_erase_prescale_q;
    logic [1:0] store_ctrl_q;
    logic [15:0] software_read_limit;
    logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic [31:0] rdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic do_write;
    logic timer_busy, timer_last;
    logic rd_upper, rd_below, rd_block;
    logic wr_upper, wr_below, fw_ok, fw_erase, tp_go, fw_go;
    logic [31:0] rd_word;
    logic rd_hit;
    localparam logic [7:0] timing_rst = `FRL_TIMING_RESET;

    assign software_read_limit = {read_limit_high_byte_q, 8'h00};

    // write path: address and data taken in either order, response after both
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b0;
            awaddr_q <= 12'h0;
        end else if (awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q <= awaddr;
        end else if (do_write || !aw_held_q) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end else if (wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
        end else if (do_write || !w_held_q) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `FRL_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (valid_index(awaddr_q, `FRL_IDX_STORE) ||
                        valid_index(awaddr_q, `FRL_IDX_TIMING) ||
                        valid_index(awaddr_q, `FRL_IDX_LIMIT) ||
                        valid_index(awaddr_q, `FRL_IDX_STATUS)) ?
                       `FRL_RESP_OKAY : `FRL_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // timing fields; bits 5:4 have no storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oneshot_timer_en_q <= timing_rst[`FRL_TM_ONESHOT];
            read_always_en_q <= timing_rst[`FRL_TM_READ_ALWAYS];
            write_erase_prescale_q <= timing_rst[3:0];
        end else if (do_write && wstrb0_q && valid_index(awaddr_q, `FRL_IDX_TIMING)) begin
            oneshot_timer_en_q <= wdata_q[`FRL_TM_ONESHOT];
            read_always_en_q <= wdata_q[`FRL_TM_READ_ALWAYS];
            write_erase_prescale_q <= wdata_q[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_limit_high_byte_q <= `FRL_LIMIT_RESET;
            limit_written_q <= 1'b0;
        end else if (do_write && wstrb0_q && valid_index(awaddr_q, `FRL_IDX_LIMIT)
                     && !limit_written_q) begin
            read_limit_high_byte_q <= wdata_q[7:0];
            limit_written_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            store_ctrl_q <= `FRL_STORE_RESET;
        end else if (do_write && wstrb0_q && valid_index(awaddr_q, `FRL_IDX_STORE)) begin
            store_ctrl_q <= wdata_q[1:0];
        end
    end

    // read path
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        if (valid_index(araddr, `FRL_IDX_STORE)) begin
            rd_word = {30'h0, store_ctrl_q};
        end else if (valid_index(araddr, `FRL_IDX_TIMING)) begin
            rd_word = {24'h0, oneshot_timer_en_q, read_always_en_q, 2'b00,
                       write_erase_prescale_q};
        end else if (valid_index(araddr, `FRL_IDX_LIMIT)) begin
            rd_word = {24'h0, read_limit_high_byte_q};
        end else if (valid_index(araddr, `FRL_IDX_STATUS)) begin
            rd_word = {30'h0, timer_busy, limit_written_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `FRL_RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `FRL_RESP_OKAY : `FRL_RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // partitions from instruction and operand addresses
    assign rd_upper = cur_pc >= software_read_limit;
    assign rd_below = rd_addr < software_read_limit;
    assign wr_upper = cur_pc >= software_read_limit;
    assign wr_below = wr_addr < software_read_limit;

    // only data reads are masked; lock bytes stay visible
    assign rd_block = rd_upper && rd_below && !rd_is_fetch && !is_lock_byte(rd_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            rd_valid_q <= rd_req;
            if (rd_req) begin
                rd_data_q <= rd_block ? 8'h00 : flash_rdata;
            end
        end
    end

    assign fw_erase = store_ctrl_q[`FRL_ST_ERASE_EN];
    assign fw_ok = store_ctrl_q[`FRL_ST_WRITE_EN]
                   && (write_erase_prescale_q != `FRL_PRESC_OFF)
                   && !(wr_upper && wr_below && !is_lock_byte(wr_addr))
                   && !(fw_erase && in_lock_sector(wr_addr));
    // test port wins; a request during a running operation is dropped
    assign tp_go = tp_erase_req && !timer_busy;
    assign fw_go = wr_req && fw_ok && !timer_busy && !tp_erase_req;

    // lock sector only erased from the test port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fl_cmd_valid_q <= 1'b0;
            fl_cmd_q <= frl_pkg::OP_NONE;
            fl_addr_q <= 16'h0;
            fl_wdata_q <= 8'h00;
        end else begin
            fl_cmd_valid_q <= tp_go || fw_go;
            if (tp_go) begin
                fl_cmd_q <= is_lock_byte(tp_erase_addr) ? frl_pkg::OP_MASS : frl_pkg::OP_SECTOR;
                fl_addr_q <= {tp_erase_addr[15:9], 9'h000};
            end else if (fw_go) begin
                fl_cmd_q <= fw_erase ? frl_pkg::OP_SECTOR : frl_pkg::OP_PROG;
                fl_addr_q <= fw_erase ? {wr_addr[15:9], 9'h000} : wr_addr;
                fl_wdata_q <= wr_data;
            end else begin
                fl_cmd_q <= frl_pkg::OP_NONE;
            end
        end
    end

    frl_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(tp_go || fw_go),
        .long_op(tp_go || fw_erase),
        .prescale(write_erase_prescale_q),
        .busy(timer_busy),
        .last(timer_last)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_stall_q <= 1'b0;
        end else begin
            cpu_stall_q <= tp_go || fw_go || (timer_busy && !timer_last);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_prog_start;
        fl_cmd_valid_q && fl_cmd_q == frl_pkg::OP_PROG;
    endsequence

    sequence s_stall_two;
        cpu_stall_q [*2];
    endsequence

    a_read_zero_block: assert property (
        rd_req && !rd_is_fetch && rd_upper && rd_below && !is_lock_byte(rd_addr)
        |=> rd_valid_q && rd_data_q == 8'h00)
        else $error("blocked read did not return zero");
    a_fetch_passes: assert property (
        rd_req && rd_is_fetch |=> rd_data_q == $past(flash_rdata))
        else $error("fetch data was altered");
    a_lower_free: assert property (
        rd_req && (cur_pc < software_read_limit) |=> rd_data_q == $past(flash_rdata))
        else $error("lower partition read was altered");
    a_limit_once: assert property (
        limit_written_q |=> $stable(read_limit_high_byte_q) && limit_written_q)
        else $error("limit changed after first write");
    a_upper_write_block: assert property (
        wr_req && !tp_erase_req && wr_upper && wr_below && !is_lock_byte(wr_addr)
        |=> !fl_cmd_valid_q)
        else $error("upper code wrote below limit");
    a_presc_off: assert property (
        wr_req && !tp_erase_req && write_erase_prescale_q == `FRL_PRESC_OFF
        |=> !fl_cmd_valid_q)
        else $error("write issued with prescaler disabled");
    a_unused_zero: assert property (
        arvalid && arready_q && valid_index(araddr, `FRL_IDX_TIMING) |=> rdata_q[5:4] == 2'b00)
        else $error("unused timing bits read nonzero");
    a_prog_stall: assert property (
        s_prog_start |-> s_stall_two)
        else $error("program did not stall the core");
    a_lock_fw_erase: assert property (
        wr_req && !tp_erase_req && fw_erase && in_lock_sector(wr_addr) |=> !fl_cmd_valid_q)
        else $error("firmware erased the lock sector");
    a_mass_erase: assert property (
        tp_go && is_lock_byte(tp_erase_addr)
        |=> fl_cmd_valid_q && fl_cmd_q == frl_pkg::OP_MASS)
        else $error("lock byte erase was not a mass erase");
    a_lock_page_erase: assert property (
        tp_go && in_lock_sector(tp_erase_addr) && !is_lock_byte(tp_erase_addr)
        |=> fl_cmd_q == frl_pkg::OP_SECTOR && fl_addr_q == 16'h7c00)
        else $error("lock page erase wrong");
endmodule // frl_top
`default_nettype wire
